/* File: src/asrm_pkg.sv */
/*
  Package for the host controller of a 64K x 4 asynchronous static memory.
  Assumes one 40 MHz system clock; the memory itself has no clock.
*/
package asrm_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;
  localparam real CLK_NS = 25.0;
  // Phase lengths in ns, chosen to cover the slowest speed grade.
  localparam real SETUP_NS = 25.0;
  localparam real PULSE_NS = 50.0;
  localparam real RECOV_NS = 25.0;
  localparam int SETUP_CYC = (int'($ceil(SETUP_NS / CLK_NS)) < 1) ? 1
    : int'($ceil(SETUP_NS / CLK_NS));
  localparam int PULSE_CYC = (int'($ceil(PULSE_NS / CLK_NS)) < 1) ? 1
    : int'($ceil(PULSE_NS / CLK_NS));
  localparam int RECOV_CYC = (int'($ceil(RECOV_NS / CLK_NS)) < 1) ? 1
    : int'($ceil(RECOV_NS / CLK_NS));
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [4:0] {
    ASRM_IDLE = 5'b0_0001,
    ASRM_SETUP = 5'b0_0010,
    ASRM_PULSE = 5'b0_0100,
    ASRM_RECOV = 5'b0_1000,
    ASRM_DONE = 5'b1_0000
  } asrm_state_t;

  // Pin group driven toward the memory; strobes are active low.
  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] address_inputs;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } asrm_pins_t;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrm_req_t;
endpackage

/* File: src/asrm_sync.sv */
/*
  Two-stage synchroniser for the shared data pins read back from the memory.
  Assumes the pins change with no relation to sys_clk.
*/
`timescale 1ns/1ps
module asrm_sync
  import asrm_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data.
  input wire logic [DATA_W-1:0] async_in,
  output logic [DATA_W-1:0] sync_out
);
  typedef struct packed {
    logic [DATA_W-1:0] meta;
    logic [DATA_W-1:0] stable;
  } asrm_sync_t;

  asrm_sync_t st_ff;
  asrm_sync_t nxt_st;

  always_comb
  begin
    nxt_st.meta = async_in;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign sync_out = st_ff.stable;
endmodule

/* File: src/asrm_host.sv */
/*
  Host controller for a 64K x 4 asynchronous static memory with shared data pins.
  Takes one read or write request at a time and plays it out on the memory pins.
  Assumes the user holds a request until req_ready and that the pad resolves the
  shared data wire from data_oe of mem_pins.
*/
`timescale 1ns/1ps
module asrm_host
  import asrm_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // User request.
  input wire logic req_valid,
  input wire asrm_req_t req,
  output logic req_ready,
  // User answer.
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Memory pins.
  output asrm_pins_t mem_pins,
  input wire logic [DATA_W-1:0] shared_data_in
);
  typedef struct packed {
    asrm_state_t state;
    logic [CNT_W-1:0] cnt;
    logic write;
    asrm_pins_t pins;
    logic ready;
    logic rsp_valid;
    logic [DATA_W-1:0] rdata;
  } asrm_host_t;

  localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] PULSE_LD = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0] RECOV_LD = CNT_W'(RECOV_CYC);

  asrm_host_t st_ff;
  asrm_host_t nxt_st;
  logic [DATA_W-1:0] data_sync;

  // Read data cross into sys_clk through two flops, so a read samples the pins
  // two cycles before it reports; the recovery phase of a read allows for that.
  asrm_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(shared_data_in),
    .sync_out(data_sync)
  );

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = 1'b0;
    // The phase counter runs down on its own; each state only loads it.
    if (st_ff.cnt != CNT_ZERO)
      nxt_st.cnt = st_ff.cnt - CNT_ONE;
    case (st_ff.state)
      ASRM_IDLE:
      begin
        if (req_valid && st_ff.ready)
        begin
          // Write enable falls a cycle before select, so the memory never turns its
          // outputs on during a write; output enable stays high as a second guard.
          nxt_st.ready = 1'b0;
          nxt_st.write = req.write;
          nxt_st.pins.address_inputs = req.addr;
          nxt_st.pins.data_out = req.wdata;
          nxt_st.pins.cs_n = 1'b1;
          nxt_st.pins.we_n = ~req.write;
          nxt_st.pins.oe_n = 1'b1;
          nxt_st.pins.data_oe = req.write;
          nxt_st.cnt = SETUP_LD;
          nxt_st.state = ASRM_SETUP;
        end
      end
      ASRM_SETUP:
      begin
        if (st_ff.cnt == CNT_ONE)
        begin
          // On a write, write enable is already low, so the later strobe is select.
          nxt_st.pins.cs_n = 1'b0;
          nxt_st.pins.oe_n = st_ff.write;
          nxt_st.cnt = PULSE_LD;
          nxt_st.state = ASRM_PULSE;
        end
      end
      ASRM_PULSE:
      begin
        if (st_ff.cnt == CNT_ONE)
        begin
          // Select rises first and ends the write; data and address stay put.
          nxt_st.pins.cs_n = 1'b1;
          nxt_st.pins.oe_n = 1'b1;
          if (!st_ff.write)
            nxt_st.cnt = CNT_ONE + CNT_ONE;
          else
            nxt_st.cnt = RECOV_LD;
          nxt_st.state = ASRM_RECOV;
        end
      end
      ASRM_RECOV:
      begin
        if (st_ff.cnt == CNT_ONE)
        begin
          // Sampled late enough for the synchroniser to hold data of the pulse.
          nxt_st.rdata = st_ff.write ? st_ff.rdata : data_sync;
          nxt_st.pins.we_n = 1'b1;
          nxt_st.pins.data_oe = 1'b0;
          nxt_st.state = ASRM_DONE;
        end
      end
      ASRM_DONE:
      begin
        nxt_st.rsp_valid = 1'b1;
        nxt_st.ready = 1'b1;
        nxt_st.state = ASRM_IDLE;
      end
      default:
      begin
        nxt_st.state = ASRM_IDLE;
        nxt_st.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_ff.state <= ASRM_IDLE;
      st_ff.cnt <= CNT_ZERO;
      st_ff.write <= 1'b0;
      st_ff.pins <= {1'b1, 1'b1, 1'b1, {ADDR_W{1'b0}}, {DATA_W{1'b0}}, 1'b0};
      st_ff.ready <= 1'b1;
      st_ff.rsp_valid <= 1'b0;
      st_ff.rdata <= '0;
    end
    else
      st_ff <= nxt_st;
  end

  assign req_ready = st_ff.ready;
  assign rsp_valid = st_ff.rsp_valid;
  assign rsp_rdata = st_ff.rdata;
  assign mem_pins = st_ff.pins;

  // Host never drives data while the memory is in read mode.
  a_no_bus_fight: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!st_ff.pins.cs_n && !st_ff.pins.oe_n && st_ff.pins.we_n) |-> !st_ff.pins.data_oe)
    else $error("host drives data during read mode");

  a_write_overlap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($fell(st_ff.pins.cs_n) && !st_ff.pins.we_n) |->
      (!st_ff.pins.we_n && st_ff.pins.data_oe)[*2])
    else $error("write strobes not held low together");

  a_cs_after_we: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(st_ff.pins.we_n) |-> st_ff.pins.cs_n)
    else $error("select fell before write enable");

  a_read_strobes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($fell(st_ff.pins.oe_n)) |-> (!st_ff.pins.cs_n && st_ff.pins.we_n))
    else $error("read strobes wrong");

  a_data_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(st_ff.pins.cs_n) && !st_ff.pins.we_n) |->
      ($stable(st_ff.pins.address_inputs) && st_ff.pins.data_oe))
    else $error("write data or address moved at write end");

  a_oe_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_ff.pins.cs_n |-> st_ff.pins.oe_n)
    else $error("output enable low while deselected");

  a_resp_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req_valid && req_ready) |-> ##[4:12] rsp_valid)
    else $error("no response in time");

  a_ready_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rsp_valid |-> (req_ready && mem_pins.cs_n && !mem_pins.data_oe))
    else $error("response while bus busy");

  // The checks below assume the one, two and one cycle phases of the package;
  // a change of phase lengths must revisit the pulse length check.
  a_addr_steady: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !st_ff.pins.cs_n |-> $stable(st_ff.pins.address_inputs))
    else $error("address moved while selected");

  a_pulse_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(st_ff.pins.cs_n) |-> ##1 !st_ff.pins.cs_n ##1 st_ff.pins.cs_n)
    else $error("select pulse length wrong");

  a_drive_write_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_ff.pins.data_oe |-> !st_ff.pins.we_n)
    else $error("host drives data outside a write");

  a_read_oe_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!st_ff.pins.cs_n && st_ff.pins.we_n) |-> !st_ff.pins.oe_n)
    else $error("read selected without output enable");

  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_ff.state == ASRM_IDLE) |->
      (st_ff.pins.cs_n && st_ff.pins.we_n && st_ff.pins.oe_n && !st_ff.pins.data_oe))
    else $error("strobes active while idle");

  a_one_access: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_ff.ready |-> (st_ff.state == ASRM_IDLE))
    else $error("ready outside idle");

  a_rsp_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_ff.rsp_valid |=> !st_ff.rsp_valid)
    else $error("response longer than one cycle");
endmodule

/* File: testbench/asrm_mem_model.sv */
/*
  Behavioural model of the 64K x 4 static memory on the host's pins.
  Assumes the bench resolves the shared data wire from both enables.
*/
`timescale 1ns/1ps
module asrm_mem_model
  import asrm_pkg::*;
(
  // Control and address.
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [ADDR_W-1:0] address_inputs,
  // Shared data pins.
  input wire logic [DATA_W-1:0] bus,
  output logic [DATA_W-1:0] dev_data,
  output logic dev_oe
);
  logic [DATA_W-1:0] words [0:65535];
  wire rd = !cs_n && we_n && !oe_n;
  wire wr = !cs_n && !we_n;
  initial dev_data = 4'h0;
  always @(rd or address_inputs)
  begin
    if (rd)
      dev_data = words[address_inputs];
  end
  // Outputs float as soon as read mode ends, so a late host sample sees junk.
  assign dev_oe = rd;
  always @(negedge wr)
    words[address_inputs] = bus;
endmodule

/* File: testbench/asrm_host_bench.sv */
/*
  Self-checking bench for the static memory host controller.
  Assumes the memory model drives the far side of the shared data pins.
*/
`timescale 1ns/1ps
module asrm_host_bench
  import asrm_pkg::*;
;
  typedef struct {asrm_req_t r; logic [3:0] exp;} asrm_row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  asrm_req_t req = '0;
  logic req_ready, rsp_valid, dev_oe;
  logic [3:0] rsp_rdata, dev_data, bus;
  logic [3:0] floatv = 4'h5;
  asrm_pins_t pins;
  int errors = 0;
  int total_checks = 0;
  int k;
  asrm_row_t rows[9] = '{'{'{1'b1, 16'h0000, 4'ha}, 4'h0}, '{'{1'b1, 16'hffff, 4'h5}, 4'h0},
    '{'{1'b1, 16'h1234, 4'hf}, 4'h0}, '{'{1'b0, 16'h0000, 4'h0}, 4'ha},
    '{'{1'b0, 16'hffff, 4'h0}, 4'h5}, '{'{1'b1, 16'h0000, 4'h3}, 4'h0},
    '{'{1'b0, 16'h0000, 4'h0}, 4'h3}, '{'{1'b0, 16'h1234, 4'h0}, 4'hf},
    '{'{1'b0, 16'hffff, 4'h0}, 4'h5}};
  always #12.5 sys_clk = ~sys_clk;
  // A released wire must not keep its last level, so it toggles every cycle.
  always @(posedge sys_clk) floatv <= ~floatv;
  assign bus = pins.data_oe ? pins.data_out : (dev_oe ? dev_data : floatv);
  asrm_host dut(.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_pins(pins),
    .shared_data_in(bus));
  asrm_mem_model u_mem(.cs_n(pins.cs_n), .we_n(pins.we_n), .oe_n(pins.oe_n),
    .address_inputs(pins.address_inputs), .bus(bus), .dev_data(dev_data), .dev_oe(dev_oe));
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp_data(input string n, input logic [3:0] e, input logic [3:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic take();
    for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(posedge sys_clk);
    if (k == 20)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic finish(input asrm_row_t w);
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      if (rsp_valid === 1'b1) break;
    end
    if (k == 20)
    begin
      errors++;
      report_and_stop();
    end
    cmp_data("latency", w.r.write ? 4'h6 : 4'h7, 4'(k + 1));
    cmp_bit("ready_at_rsp", 1'b1, req_ready);
    if (!w.r.write) cmp_data("rdata", w.exp, rsp_rdata);
  endtask
  always @(posedge sys_clk)
  begin
    if (rst_n)
    begin
      cmp_bit("contention", 1'b0, pins.data_oe & dev_oe);
      cmp_bit("oe_in_write", 1'b0, ~pins.oe_n & ~pins.we_n);
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    cmp_bit("reset_cs", 1'b1, pins.cs_n);
    cmp_bit("reset_oe", 1'b0, pins.data_oe);
    rst_n <= 1'b1;
    req_valid <= 1'b1;
    req <= rows[0].r;
    @(posedge sys_clk);
    take();
    for (int i = 0; i < 9; i++)
    begin
      if (i == 8)
        req_valid <= 1'b0;
      else
        req <= rows[i + 1].r;
      finish(rows[i]);
    end
    req_valid <= 1'b1;
    req <= rows[0].r;
    @(posedge sys_clk);
    take();
    req_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cmp_bit("abort_cs", 1'b1, pins.cs_n);
    cmp_bit("abort_we", 1'b1, pins.we_n);
    cmp_bit("abort_ready", 1'b1, req_ready);
    rst_n <= 1'b1;
    req_valid <= 1'b1;
    req <= rows[4].r;
    @(posedge sys_clk);
    take();
    req_valid <= 1'b0;
    finish(rows[4]);
    report_and_stop();
  end
endmodule
